// *** dsli_asserts.sv ***
`timescale 1ns/10ps
module dsli_asserts #(
	parameter bit WIDE = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// link wires
	input wire logic frame_sel_n,
	input wire logic sclk,
	input wire logic sdata
);
	localparam int FLEN = WIDE ? dsli_pkg::FRAME_LEN_16 : dsli_pkg::FRAME_LEN_14;
	int nfall;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// falls seen in the open frame; cleared while deselected
	always_ff @(posedge clk)
		if (!resetn || frame_sel_n)
			nfall <= 0;
		else if ($fell(sclk))
			nfall <= nfall + 1;
	////////////////////////////////////////////////////////////////
	AST_GAP: assert property ($rose(frame_sel_n) |=> frame_sel_n) else $error("select gap short");
	AST_CPOL: assert property ($fell(frame_sel_n) |-> !$past(sclk)) else $error("sclk high at start");
	AST_HALF: assert property ($changed(sclk) && !frame_sel_n |=> $stable(sclk) [*3]) else $error("sclk fast");
	AST_DHOLD: assert property ($fell(sclk) && !frame_sel_n |-> $stable(sdata) ##1 $stable(sdata))
		else $error("data moved at fall");
	AST_DMOVE: assert property (!frame_sel_n && $changed(sdata) |-> $rose(sclk)) else $error("data moved");
	AST_QUIET: assert property (frame_sel_n [*3] |-> !sclk) else $error("sclk idle high");
	AST_HOLD: assert property (!frame_sel_n && nfall < FLEN |=> !frame_sel_n) else $error("frame cut");
	AST_COUNT: assert property ($rose(frame_sel_n) |-> nfall == FLEN) else $error("bad fall count");
endmodule

// *** dsli_bench.sv ***
`timescale 1ns/10ps
module dsli_bench;
	logic clk, resetn, wr, rd;
	logic [1:0] addr, pd_mode, pd_n, pd_w, mn, mw;
	logic [31:0] wdata, rdata, rv;
	logic [15:0] code, code_n, code_w, xn, xw;
	logic oe, p1k, p100k, lp;
	int n_errors = 0;
	int checked = 0;
	int nload = 0;
	// ordinary frames: {out_enable, pd_1k, pd_100k, word}
	logic [18:0] rows [4] = '{19'h43FFF, 19'h24001, 19'h1AAAA, 19'h0C000};
	// hand-made frames and their fall counts
	logic [23:0] bw [4] = '{24'hB5A5C3, 24'h6F0F3C, 24'hC3C3C3, 24'h5A5A5A};
	int bn [4] = '{24, 17, 15, 18};
	dsli_if link ();
	dsli_if link_b ();
	dsli_ctrl #(.WIDE(1'b0)) u_dsli_ctrl (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .link(link));
	dsli_device #(.WIDE(1'b0)) u_dsli_device (.clk(clk), .resetn(resetn), .link(link), .code(code),
		.pd_mode(pd_mode), .out_enable(oe), .pd_1k(p1k), .pd_100k(p100k), .load_pulse(lp));
	dsli_device u_dsli_device_n (.clk(clk), .resetn(resetn), .link(link_b), .code(code_n),
		.pd_mode(pd_n), .out_enable(), .pd_1k(), .pd_100k(), .load_pulse());
	dsli_device #(.WIDE(1'b1)) u_dsli_device_w (.clk(clk), .resetn(resetn), .link(link_b), .code(code_w),
		.pd_mode(pd_w), .out_enable(), .pd_1k(), .pd_100k(), .load_pulse());
	dsli_asserts #(.WIDE(1'b0)) u_dsli_asserts (.clk(clk), .resetn(resetn), .frame_sel_n(link.frame_sel_n),
		.sclk(link.sclk), .sdata(link.sdata));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wr_reg(input logic [1:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask
	task automatic rd_reg(input logic [1:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1 rv = rdata;
	endtask
	// plays a controller that may cut a frame short
	task automatic bang(input logic [23:0] w, input int n);
		@(posedge clk);
		link_b.frame_sel_n <= 1'h0;
		for (int i = 0; i < n; i++) begin
			link_b.sclk <= 1'h1;
			link_b.sdata <= w[23-i];
			repeat (4) @(posedge clk);
			link_b.sclk <= 1'h0;
			repeat (4) @(posedge clk);
		end
		link_b.frame_sel_n <= 1'h1;
		// released line must not keep showing the last bit
		link_b.sdata <= ~link_b.sdata;
		repeat (8) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk)
		if (lp === 1'h1)
			nload++;
	initial begin
		#200000;
		n_errors++;
		report_and_stop();
	end
	initial begin
		{resetn, wr, rd, addr, wdata} = '0;
		{link_b.frame_sel_n, link_b.sclk, link_b.sdata} = 3'h4;
		{xn, xw, mn, mw} = '0;
		repeat (2) @(posedge clk);
		resetn <= 1'h1;
		rd_reg(2'h3);
		chk(rv, 32'h0);
		chk({pd_mode, code}, 18'h0);
		for (int i = 0; i < 4; i++) begin
			wr_reg(dsli_pkg::REG_DATA, {16'h0, rows[i][15:0]});
			rd_reg(dsli_pkg::REG_DATA);
			chk(rv, {16'h0, rows[i][15:0]});
			wr_reg(dsli_pkg::REG_CTRL, 32'h1);
			repeat (200) begin
				rd_reg(dsli_pkg::REG_STATUS);
				if (rv[1:0] === 2'h2)
					break;
			end
			chk(rv[1:0], 2'h2);
			repeat (4) @(posedge clk);
			chk(code, {2'h0, rows[i][13:0]});
			chk(pd_mode, rows[i][15:14]);
			chk({oe, p1k, p100k}, rows[i][18:16]);
			wr_reg(dsli_pkg::REG_STATUS, 32'h0);
			rd_reg(dsli_pkg::REG_STATUS);
			chk(rv, 32'h0);
			$display("frame %0d done", i);
		end
		chk(nload, 4);
		for (int i = 0; i < 4; i++) begin
			bang(bw[i], bn[i]);
			if (bn[i] >= 16) begin
				mn = bw[i][23:22];
				xn = {2'h0, bw[i][21:8]};
			end
			if (bn[i] >= 18) begin
				mw = bw[i][23:22];
				xw = bw[i][21:6];
			end
			chk(code_n, xn);
			chk(pd_n, mn);
			chk(code_w, xw);
			chk(pd_w, mw);
			$display("cut frame %0d done", i);
		end
		// reset in mid-run returns every end to its power-on state
		resetn <= 1'h0;
		repeat (2) @(posedge clk);
		chk({pd_mode, code}, 18'h0);
		chk({pd_n, code_n}, 18'h0);
		chk({pd_w, code_w}, 18'h0);
		resetn <= 1'h1;
		rd_reg(dsli_pkg::REG_STATUS);
		chk(rv, 32'h0);
		$display("reset test done");
		report_and_stop();
	end
endmodule

// *** dsli_ctrl.sv ***
`timescale 1ns/10ps
module dsli_ctrl #(
	parameter bit WIDE = 1'b0,
	parameter int SCLK_HALF = dsli_pkg::SCLK_HALF_DEFAULT
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// register port
	input wire logic [1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// link
	dsli_if.ctrl link
);
	localparam int FLEN = WIDE ? dsli_pkg::FRAME_LEN_16 : dsli_pkg::FRAME_LEN_14;
	localparam int HW = 8;

	typedef enum logic [1:0] {
		DSLI_IDLE = 2'b00,
		DSLI_LOW = 2'b01,
		DSLI_HIGH = 2'b10,
		DSLI_GAP = 2'b11
	} dsli_state_e;

	dsli_state_e st, next_st;
	logic [23:0] data, next_data;
	logic [23:0] sh, next_sh;
	logic [4:0] bits, next_bits;
	logic [HW-1:0] tmr, next_tmr;
	logic done, next_done;
	logic [31:0] next_rdata;
	logic sel_n, next_sel_n, sck, next_sck;

	assign link.frame_sel_n = sel_n;
	assign link.sclk = sck;
	assign link.sdata = sh[FLEN-1];

	////////////////////////////////////////////////////////////
	always_comb begin
		next_st = st;
		next_data = data;
		next_sh = sh;
		next_bits = bits;
		next_tmr = tmr;
		next_done = done;
		next_sel_n = sel_n;
		next_sck = sck;
		next_rdata = 32'h00000000;
		if (wr && addr == dsli_pkg::REG_DATA)
			next_data = wdata[23:0];
		if (rd) begin
			case (addr)
				dsli_pkg::REG_DATA: next_rdata = {8'h00, data};
				dsli_pkg::REG_STATUS: next_rdata = {30'h0, done, st != DSLI_IDLE};
				default: next_rdata = 32'h00000000;
			endcase
		end
		if (wr && addr == dsli_pkg::REG_STATUS)
			next_done = 1'b0;
		unique case (st)
			DSLI_IDLE: begin
				if (wr && addr == dsli_pkg::REG_CTRL && wdata[dsli_pkg::CTRL_GO_BIT]) begin
					// whole frame under one select low, msb first
					next_sh = (wr && addr == dsli_pkg::REG_DATA) ? wdata[23:0] : data;
					next_sel_n = 1'b0;
					next_sck = 1'b1;
					next_bits = '0;
					next_tmr = HW'(SCLK_HALF - 1);
					next_st = DSLI_HIGH;
				end
			end
			DSLI_HIGH: begin
				if (tmr == '0) begin
					next_sck = 1'b0; // device samples here
					next_tmr = HW'(SCLK_HALF - 1);
					next_bits = bits + 5'h01;
					next_st = DSLI_LOW;
				end else
					next_tmr = tmr - 8'h01;
			end
			DSLI_LOW: begin
				if (tmr == '0) begin
					next_sck = 1'b1;
					next_tmr = HW'(SCLK_HALF - 1);
					if (bits == 5'(FLEN)) begin
						next_sel_n = 1'b1;
						next_tmr = HW'(dsli_pkg::SYNC_HIGH_CYC);
						next_st = DSLI_GAP;
					end else begin
						next_sh = {sh[22:0], 1'b0};
						next_st = DSLI_HIGH;
					end
				end else
					next_tmr = tmr - 8'h01;
			end
			DSLI_GAP: begin
				next_sck = 1'b0;
				if (tmr == '0) begin
					next_done = 1'b1;
					next_st = DSLI_IDLE;
				end else
					next_tmr = tmr - 8'h01;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			st <= DSLI_IDLE;
			data <= 24'h000000;
			sh <= 24'h000000;
			bits <= 5'h00;
			tmr <= 8'h00;
			done <= 1'b0;
			rdata <= 32'h00000000;
			sel_n <= 1'b1;
			sck <= 1'b0;
		end else begin
			st <= next_st;
			data <= next_data;
			sh <= next_sh;
			bits <= next_bits;
			tmr <= next_tmr;
			done <= next_done;
			rdata <= next_rdata;
			sel_n <= next_sel_n;
			sck <= next_sck;
		end
	end
endmodule

// *** dsli_device.sv ***
`timescale 1ns/10ps
module dsli_device #(
	parameter bit WIDE = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// link
	dsli_if.dev link,
	// converter side
	output logic [15:0] code,
	output logic [1:0] pd_mode,
	output logic out_enable,
	output logic pd_1k,
	output logic pd_100k,
	output logic load_pulse
);
	localparam int FLEN = WIDE ? dsli_pkg::FRAME_LEN_16 : dsli_pkg::FRAME_LEN_14;
	localparam int CLEN = WIDE ? dsli_pkg::CODE_LEN_16 : dsli_pkg::CODE_LEN_14;
	localparam int MLEN = dsli_pkg::MODE_BITS;
	// the fall that executes the frame: 16th or 18th
	localparam int EXEC = MLEN + CLEN;
	localparam int CW = 5;

	typedef enum logic [1:0] {
		DSLI_RX_IDLE = 2'b00,
		DSLI_RX_SHIFT = 2'b01,
		DSLI_RX_DONE = 2'b10
	} dsli_rx_state_e;

	// synchronised pins
	logic [2:0] pins;
	logic sel_n;
	logic sck;
	logic sd;
	// pin history for edge detection
	logic sel_d;
	logic sck_d;
	logic next_sel_d;
	logic next_sck_d;
	logic sel_fall;
	logic sck_fall;
	// frame receiver
	dsli_rx_state_e rx_st;
	dsli_rx_state_e next_rx_st;
	logic [FLEN-1:0] shreg;
	logic [FLEN-1:0] next_shreg;
	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic exec;
	logic [EXEC-1:0] word;
	// results
	logic [15:0] next_code;
	logic [1:0] next_pd_mode;
	logic next_load;
	logic [3:0] mode_hot;

	////////////////////////////////////////////////////////////
	// edge test on synchronised levels
	function automatic logic dsli_fell(input logic prev, input logic now);
		return prev & ~now;
	endfunction

	// one-hot view of the mode bits; all zero never occurs
	function automatic logic [3:0] dsli_mode_hot(input logic [1:0] mode);
		logic [3:0] hot;
		hot = 4'h0;
		hot[mode] = 1'b1;
		return hot;
	endfunction

	////////////////////////////////////////////////////////////
	dsli_sync #(.WIDTH(3)) u_sync (
		.clk(clk),
		.resetn(resetn),
		.din({link.frame_sel_n, link.sclk, link.sdata}),
		.dout(pins)
	);
	assign sel_n = pins[2];
	assign sck = pins[1];
	assign sd = pins[0];

	////////////////////////////////////////////////////////////
	always_comb begin
		next_sel_d = sel_n;
		next_sck_d = sck;
	end

	// history resets to the synchroniser's idle output, so leaving reset shows no false select fall
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sel_d <= 1'b1;
			sck_d <= 1'b1;
		end else begin
			sel_d <= next_sel_d;
			sck_d <= next_sck_d;
		end
	end

	assign sel_fall = dsli_fell(sel_d, sel_n);
	assign sck_fall = dsli_fell(sck_d, sck);

	////////////////////////////////////////////////////////////
	always_comb begin
		next_rx_st = rx_st;
		next_shreg = shreg;
		next_cnt = cnt;
		exec = 1'b0;
		word = '0;
		unique case (rx_st)
			DSLI_RX_IDLE: begin
				// a frame opens only on a fresh select fall
				if (sel_fall) begin
					next_shreg = '0;
					next_cnt = '0;
					next_rx_st = DSLI_RX_SHIFT;
				end
			end
			DSLI_RX_SHIFT: begin
				if (sel_n) begin
					// select up before the executing fall throws the frame away
					next_shreg = '0;
					next_cnt = '0;
					next_rx_st = DSLI_RX_IDLE;
				end else if (sck_fall) begin
					next_shreg = {shreg[FLEN-2:0], sd};
					next_cnt = cnt + CW'(1);
					if (cnt == CW'(EXEC - 1)) begin
						exec = 1'b1;
						word = {shreg[EXEC-2:0], sd};
						next_rx_st = DSLI_RX_DONE;
					end
				end
			end
			DSLI_RX_DONE: begin
				// later falls and a late select rise leave the result alone
				if (sel_n) begin
					next_shreg = '0;
					next_cnt = '0;
					next_rx_st = DSLI_RX_IDLE;
				end
			end
			default: begin
				next_shreg = '0;
				next_cnt = '0;
				next_rx_st = DSLI_RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rx_st <= DSLI_RX_IDLE;
			shreg <= '0;
			cnt <= '0;
		end else begin
			rx_st <= next_rx_st;
			shreg <= next_shreg;
			cnt <= next_cnt;
		end
	end

	////////////////////////////////////////////////////////////
	always_comb begin
		next_code = code;
		next_pd_mode = pd_mode;
		next_load = 1'b0;
		if (exec) begin
			next_pd_mode = word[EXEC-1 -: MLEN];
			next_code = 16'(word[CLEN-1:0]);
			next_load = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			code <= dsli_pkg::CODE_RESET;
			pd_mode <= dsli_pkg::MODE_RESET;
			load_pulse <= 1'b0;
		end else begin
			code <= next_code;
			pd_mode <= next_pd_mode;
			load_pulse <= next_load;
		end
	end

	// output stage follows the mode; high impedance is all three low
	assign mode_hot = dsli_mode_hot(pd_mode);

	always_comb begin
		out_enable = mode_hot[dsli_pkg::PD_NORMAL];
		pd_1k = mode_hot[dsli_pkg::PD_1K];
		pd_100k = mode_hot[dsli_pkg::PD_100K];
	end
endmodule

// *** dsli_if.sv ***
`timescale 1ns/10ps
interface dsli_if;
	logic frame_sel_n;
	logic sclk;
	logic sdata;
	modport ctrl (output frame_sel_n, output sclk, output sdata);
	modport dev (input frame_sel_n, input sclk, input sdata);
endinterface

// *** dsli_pkg.sv ***
package dsli_pkg;
	// frame variants
	localparam int FRAME_LEN_14 = 16;
	localparam int CODE_LEN_14 = 14;
	localparam int FRAME_LEN_16 = 24;
	localparam int CODE_LEN_16 = 16;
	localparam int MODE_BITS = 2;
	// power-down modes
	localparam logic [1:0] PD_NORMAL = 2'h0;
	localparam logic [1:0] PD_1K = 2'h1;
	localparam logic [1:0] PD_100K = 2'h2;
	localparam logic [1:0] PD_HIZ = 2'h3;
	// reset values
	localparam logic [15:0] CODE_RESET = 16'h0000;
	localparam logic [1:0] MODE_RESET = 2'h0;
	// controller shift-clock divider: half period in system clocks
	localparam int CLK_HZ = 50000000;
	localparam int SCLK_HALF_DEFAULT = 4;
	// least frame-select high time between writes
	localparam int SYNC_HIGH_NS = 20;
	localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
	localparam int SYNC_HIGH_CYC = (SYNC_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
		(SYNC_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// controller register map
	localparam logic [1:0] REG_DATA = 2'h0;
	localparam logic [1:0] REG_CTRL = 2'h1;
	localparam logic [1:0] REG_STATUS = 2'h2;
	localparam int CTRL_GO_BIT = 0;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_DONE_BIT = 1;
endpackage

// *** dsli_sync.sv ***
`timescale 1ns/10ps
module dsli_sync #(
	parameter int WIDTH = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// asynchronous in, synchronous out
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_dout;

	always_comb begin
		next_stage1 = din;
		next_dout = stage1;
	end

	// idle pattern is all ones so that a select looks high from reset
	always_ff @(posedge clk) begin
		if (!resetn) begin
			stage1 <= '1;
			dout <= '1;
		end else begin
			stage1 <= next_stage1;
			dout <= next_dout;
		end
	end
endmodule
